/* rtl/output_conditioner.sv */
// output conditioning: on/off, input-error substitution, stop values,
// rate limiting, supply feed-forward and output clamping
// assumes all inputs come from logic on I_SYS_CLK
`timescale 1ns/1ps
module output_conditioner
   import outcond_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
) (
   input wire logic I_SYS_CLK, // 50 MHz
   input wire logic I_RST, // async, high
   input wire logic I_RUN, // 1 run, 0 stop
   input wire logic I_DIRECT_ACTION, // 0 reverse, 1 direct
   input wire logic [15:0] I_PROP_BAND, // zero means on/off
   input wire logic signed [15:0] I_MEASURED_VALUE, // process value
   input wire logic signed [15:0] I_SET_VALUE, // target value
   input wire gap_t I_ONOFF_GAP_SETTING, // switching gaps
   input wire pct_t I_PID_HEAT, // computed heat output
   input wire pct_t I_PID_COOL, // computed cool output
   input wire logic I_MANUAL_SEL, // pulse, operator selects manual
   input wire logic I_AUTO_SEL, // pulse, operator selects auto
   input wire pct_t I_MANUAL_MV, // manual output value
   input wire err_pair_t I_INPUT_ERROR, // error points reached
   input wire err_pair_t I_ERR_ACTION, // substitution selectors
   input wire pct_t I_ERR_MV, // output value at input error
   input wire pct_t I_STOP_HEAT, // heat value at stop
   input wire pct_t I_STOP_COOL, // cool value at stop
   input wire logic I_VALVE_MODE, // valve position control
   input wire fbr_t I_VALVE_FEEDBACK_INPUT, // feedback status
   input wire pct_t I_VALVE_STOP_MV, // valve action at stop
   input wire rate_t I_HEAT_RATE, // heat rate limits
   input wire rate_t I_COOL_RATE, // cool rate limits
   input wire clamp_t I_HEAT_CLAMP, // heat high/low limits
   input wire clamp_t I_COOL_CLAMP, // cool high/low limits
   input wire logic I_SUPPLY_FEED_FORWARD, // feed-forward selector
   input wire logic I_SUPPLY_CONNECTED, // sense transformer fitted
   input wire logic [15:0] I_SUPPLY_LEVEL, // per-mille of rated
   output pct_t O_HEAT_SIDE_OUTPUT, // conditioned heat output
   output pct_t O_COOL_SIDE_OUTPUT, // conditioned cool output
   output logic O_MANUAL_MODE, // manual or error substitution
   output logic O_ERROR_SUBST, // error value in use
   output logic O_ONOFF_STATE, // on/off output state
   output logic O_PFF_ACTIVE // feed-forward applied
);
   localparam int TW = $clog2(TICK_CYCLES + 1);

   mode_t mode;
   mode_t next_mode;
   logic [TW-1:0] tick_cnt;
   logic tick;
   logic onoff_on;
   logic err_prev;
   logic err_any;
   logic err_rise;
   logic fbr_ok;
   logic valve_nofb;
   logic onoff_mode;
   logic hi_exc;
   logic lo_exc;
   logic pff_on;
   logic signed [16:0] thr_hi;
   logic signed [16:0] thr_lo;
   pct_t computed [2];
   pct_t stop_mv [2];
   pct_t src [2];
   rate_t rate [2];
   clamp_t clamp [2];
   logic signed [31:0] lim [2];
   logic signed [31:0] next_lim [2];
   logic signed [31:0] target [2];
   logic signed [31:0] step_up [2];
   logic signed [31:0] step_dn [2];
   pct_t lim_out [2];
   pct_t final_mv [2];
   logic signed [47:0] pff_prod;
   pct_t pff_corr;

   // millisecond tick divider
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         tick_cnt <= '0;
      end else if (tick) begin
         tick_cnt <= '0;
      end else begin
         tick_cnt <= tick_cnt + 1'b1;
      end
   end
   assign tick = (tick_cnt == TW'(TICK_CYCLES - 1));

   // shared conditions
   assign fbr_ok = I_VALVE_FEEDBACK_INPUT.present & ~I_VALVE_FEEDBACK_INPUT.broken;
   assign valve_nofb = I_VALVE_MODE & ~fbr_ok;
   assign onoff_mode = (I_PROP_BAND == 16'h0000);

   // on/off switching thresholds with separate gaps
   assign thr_hi = 17'(I_SET_VALUE) + 17'($signed({1'b0, I_ONOFF_GAP_SETTING.upper}));
   assign thr_lo = 17'(I_SET_VALUE) - 17'($signed({1'b0, I_ONOFF_GAP_SETTING.lower}));
   assign hi_exc = 17'(I_MEASURED_VALUE) > thr_hi;
   assign lo_exc = 17'(I_MEASURED_VALUE) < thr_lo;

   // on/off state with hysteresis, direct action mirrors reverse
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         onoff_on <= 1'b0;
      end else if (!I_DIRECT_ACTION) begin
         if (lo_exc) begin
            onoff_on <= 1'b1;
         end else if (hi_exc) begin
            onoff_on <= 1'b0;
         end
      end else begin
         if (hi_exc) begin
            onoff_on <= 1'b1;
         end else if (lo_exc) begin
            onoff_on <= 1'b0;
         end
      end
   end

   // error detection; edge only while running so a standing error is ignored
   assign err_any = (I_INPUT_ERROR.high & I_ERR_ACTION.high)
      | (I_INPUT_ERROR.low & I_ERR_ACTION.low);
   assign err_rise = err_any & ~err_prev & I_RUN;
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         err_prev <= 1'b0;
      end else begin
         err_prev <= err_any;
      end
   end

   // operating mode
   always_comb begin
      next_mode = mode;
      case (mode)
         M_AUTO: begin
            if (I_MANUAL_SEL) begin
               next_mode = M_MANUAL;
            end else if (err_rise) begin
               next_mode = M_ERRSUB;
            end
         end
         M_MANUAL: begin
            if (I_AUTO_SEL) begin
               next_mode = M_AUTO;
            end
         end
         M_ERRSUB: begin
            if (I_AUTO_SEL) begin
               next_mode = M_AUTO;
            end
         end
         default: next_mode = M_AUTO;
      endcase
   end
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         mode <= M_AUTO;
      end else begin
         mode <= next_mode;
      end
   end
   assign O_MANUAL_MODE = (mode != M_AUTO);
   assign O_ERROR_SUBST = (mode == M_ERRSUB);
   assign O_ONOFF_STATE = onoff_on;

   // per-channel settings
   assign computed[0] = onoff_mode ? (onoff_on ? PCT_FULL : PCT_ZERO) : I_PID_HEAT;
   assign computed[1] = onoff_mode ? PCT_ZERO : I_PID_COOL;
   assign stop_mv[0] = valve_nofb ? I_VALVE_STOP_MV : I_STOP_HEAT;
   assign stop_mv[1] = I_STOP_COOL;
   assign rate[0] = I_HEAT_RATE;
   assign rate[1] = I_COOL_RATE;
   assign clamp[0] = I_HEAT_CLAMP;
   assign clamp[1] = I_COOL_CLAMP;

   // feed-forward: scale heat output by supply deficit, added after the limiter
   assign pff_on = I_SUPPLY_FEED_FORWARD & I_SUPPLY_CONNECTED
      & (I_SUPPLY_LEVEL >= SUPPLY_MIN_OK);
   assign pff_prod = 48'(lim_out[0])
      * 48'($signed({1'b0, SUPPLY_RATED}) - $signed({1'b0, I_SUPPLY_LEVEL}))
      * 48'(PFF_RECIP);
   assign pff_corr = pff_on ? pct_t'(pff_prod >>> PFF_SHIFT) : PCT_ZERO;
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_PFF_ACTIVE <= 1'b0;
      end else begin
         O_PFF_ACTIVE <= pff_on;
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_ch
         // source priority: stop, then substitution or manual, then computed
         always_comb begin
            if (!I_RUN) begin
               src[ch] = stop_mv[ch];
            end else begin
               case (mode)
                  M_ERRSUB: src[ch] = valve_nofb ? I_VALVE_STOP_MV : I_ERR_MV;
                  M_MANUAL: src[ch] = I_MANUAL_MV;
                  default: src[ch] = computed[ch];
               endcase
            end
         end

         // rate limiter in fixed point, one step per tick
         assign target[ch] = 32'(src[ch]) <<< LIM_FRAC;
         assign step_up[ch] = 32'((32'(rate[ch].up) * 32'(STEP_MUL)) >> LIM_FRAC);
         assign step_dn[ch] = 32'((32'(rate[ch].down) * 32'(STEP_MUL)) >> LIM_FRAC);
         always_comb begin
            next_lim[ch] = lim[ch];
            if (I_VALVE_MODE) begin
               next_lim[ch] = target[ch];
            end else if (target[ch] > lim[ch]) begin
               if (rate[ch].up == 16'h0000) begin
                  next_lim[ch] = target[ch];
               end else if (tick) begin
                  next_lim[ch] = (target[ch] - lim[ch] > step_up[ch])
                     ? lim[ch] + step_up[ch] : target[ch];
               end
            end else if (target[ch] < lim[ch]) begin
               if (rate[ch].down == 16'h0000) begin
                  next_lim[ch] = target[ch];
               end else if (tick) begin
                  next_lim[ch] = (lim[ch] - target[ch] > step_dn[ch])
                     ? lim[ch] - step_dn[ch] : target[ch];
               end
            end
         end
         always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
            if (I_RST) begin
               lim[ch] <= '0;
            end else begin
               lim[ch] <= next_lim[ch];
            end
         end
         assign lim_out[ch] = pct_t'(lim[ch] >>> LIM_FRAC);

         // clamp last, skipped for valve control without good feedback
         always_comb begin
            final_mv[ch] = lim_out[ch];
            if (ch == 0) begin
               final_mv[ch] = lim_out[ch] + pff_corr;
            end
            if (!valve_nofb) begin
               if (final_mv[ch] > clamp[ch].upper) begin
                  final_mv[ch] = clamp[ch].upper;
               end else if (final_mv[ch] < clamp[ch].lower) begin
                  final_mv[ch] = clamp[ch].lower;
               end
            end
         end

         a_rate_rise: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
            (!I_VALVE_MODE && rate[ch].up != 16'h0000)
            |=> (lim[ch] - $past(lim[ch]) <= $past(step_up[ch])))
            else $error("rise exceeds step");
         a_valve_nolimit: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
            I_VALVE_MODE |=> lim[ch] == $past(target[ch]))
            else $error("valve output was limited");
      end
   endgenerate

   // registered outputs
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_HEAT_SIDE_OUTPUT <= PCT_ZERO;
         O_COOL_SIDE_OUTPUT <= PCT_ZERO;
      end else begin
         O_HEAT_SIDE_OUTPUT <= final_mv[0];
         O_COOL_SIDE_OUTPUT <= final_mv[1];
      end
   end

   a_onoff_full: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      (onoff_mode && !I_DIRECT_ACTION && lo_exc) |=> O_ONOFF_STATE)
      else $error("on/off output not turned on");
   a_onoff_hold: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      (!I_DIRECT_ACTION && onoff_on && !hi_exc) |=> onoff_on)
      else $error("on/off dropped inside gap");
   a_err_manual: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      (mode == M_AUTO && err_rise && !I_MANUAL_SEL) |=> O_ERROR_SUBST && O_MANUAL_MODE)
      else $error("no substitution on error");
   a_manual_keep: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      (mode == M_MANUAL && !I_AUTO_SEL) |=> mode == M_MANUAL)
      else $error("manual mode left");
   a_start_error: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      (mode != M_ERRSUB && $rose(I_RUN) && $past(err_any) && err_any) |=> !O_ERROR_SUBST)
      else $error("standing error substituted");
   a_stop_heat: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      (!I_RUN && !valve_nofb) |-> src[0] == I_STOP_HEAT)
      else $error("stop value not chosen");
   a_clamp_cool: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      !valve_nofb |=> O_COOL_SIDE_OUTPUT <= $past(I_COOL_CLAMP.upper)
      && O_COOL_SIDE_OUTPUT >= $past(I_COOL_CLAMP.lower) || $past(I_COOL_CLAMP.lower)
      > $past(I_COOL_CLAMP.upper))
      else $error("cool output outside limits");
   a_pff_off: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      (!I_SUPPLY_CONNECTED || I_SUPPLY_LEVEL < SUPPLY_MIN_OK) |=> !O_PFF_ACTIVE)
      else $error("feed-forward not dropped");

   // selector code 0, unused or starved feed-forward, heat limits
   a_err_code0: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      (I_ERR_ACTION == 2'b00 && mode == M_AUTO) |=> !O_ERROR_SUBST)
      else $error("substitution with code 0");
   a_pff_unused: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      !I_SUPPLY_FEED_FORWARD |=> !O_PFF_ACTIVE)
      else $error("feed-forward active while unused");
   a_pff_low: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      (I_SUPPLY_LEVEL < SUPPLY_MIN_OK) |-> pff_corr == PCT_ZERO)
      else $error("correction on low supply");
   a_clamp_heat: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      (!valve_nofb && I_HEAT_CLAMP.lower <= I_HEAT_CLAMP.upper)
      |-> final_mv[0] <= I_HEAT_CLAMP.upper && final_mv[0] >= I_HEAT_CLAMP.lower)
      else $error("heat output outside limits");
endmodule : output_conditioner

/* rtl/outcond_pkg.sv */
// constants, field layouts and modes for the output conditioning stage
// assumes one 50 MHz clock; percentages are signed counts of 0.1 %
package outcond_pkg;
   typedef logic signed [15:0] pct_t;
   localparam pct_t PCT_FULL = 16'sh03E8; // 100.0 %
   localparam pct_t PCT_ZERO = 16'sh0000; // 0.0 %
   // supply sense is in per-mille of the rated voltage
   localparam logic [15:0] SUPPLY_RATED = 16'h03E8;
   localparam logic [15:0] SUPPLY_MIN_OK = 16'h02BC; // 30 % below rated
   // 1049 / 2^20 approximates 1 / 1000
   localparam logic signed [15:0] PFF_RECIP = 16'sh0419;
   localparam int PFF_SHIFT = 20;
   // limiter keeps 10 fraction bits; step per tick = rate * 1049 >> 10
   localparam int LIM_FRAC = 10;
   localparam logic [15:0] STEP_MUL = 16'h0419;
   // rate limiter updates once per millisecond
   localparam int CLK_NS = 20;
   localparam int TICK_NS = 1000000;
   localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
   typedef struct packed {
      pct_t upper;
      pct_t lower;
   } clamp_t;
   typedef struct packed {
      logic [15:0] up; // 0.1 %/s, zero is off
      logic [15:0] down;
   } rate_t;
   typedef struct packed {
      logic [15:0] upper; // measured-value units
      logic [15:0] lower;
   } gap_t;
   typedef struct packed {
      logic high;
      logic low;
   } err_pair_t;
   typedef struct packed {
      logic present;
      logic broken;
   } fbr_t;
   typedef enum {M_AUTO, M_MANUAL, M_ERRSUB} mode_t;
endpackage : outcond_pkg

/* testbench/supply_sense.sv */
// supply sense transformer model for the feed-forward input
// assumes the bench picks fitted and level between checks
`timescale 1ns/1ps
module supply_sense (
   input wire logic i_clk, // controller clock
   input wire logic i_fitted, // transformer wired in
   input wire logic [15:0] i_level, // per-mille of rated
   output logic o_connected, // sense present
   output logic [15:0] o_level // sense reading
);
   logic [15:0] churn = 16'h5A5A;
   // an unfitted input floats, so its reading churns every cycle
   always @(posedge i_clk) churn <= ~churn + 16'h0013;
   assign o_connected = i_fitted;
   assign o_level = i_fitted ? i_level : churn;
endmodule : supply_sense

/* testbench/tb.sv */
// self-checking bench for the output conditioning stage
// assumes a 50 MHz clock and a short limiter tick
`timescale 1ns/1ps
module tb;
   import outcond_pkg::*;
   logic clk = 0, rst = 1, run = 0, man = 0, aut = 0, vm = 0, ff = 0, fit = 0, da = 0, con;
   logic [15:0] pb = 16'h0064, lvl = 16'h03E8, slv;
   logic signed [15:0] pv = 16'sh0000, sv = 16'sh0064;
   pct_t ph = '0, pc = '0, emv = '0, sh = '0, sc = '0, vs = '0, mmv = '0, oh, oc;
   gap_t gap = {16'h000A, 16'h0005};
   err_pair_t ie = '0, ea = '0;
   fbr_t fb = 2'b10;
   rate_t hr = '0, cr = '0;
   clamp_t dflt = {16'sh041A, 16'shFFCE};
   clamp_t hc = {16'sh041A, 16'shFFCE}, cc = {16'sh041A, 16'shFFCE};
   logic om, oe, oo, op;
   int error_cnt = 0, cmp_count = 0, seed = 62, i, e, st;
   int exq[$];
   int pvq[$] = '{90, 105, 111, 96, 94};
   always #10 clk = ~clk;
   // far side: supply transformer
   supply_sense sup (.i_clk(clk), .i_fitted(fit), .i_level(lvl), .o_connected(con),
      .o_level(slv));
   output_conditioner #(.TICK_CYCLES(10)) uut (.I_SYS_CLK(clk), .I_RST(rst), .I_RUN(run),
      .I_DIRECT_ACTION(da), .I_PROP_BAND(pb), .I_MEASURED_VALUE(pv), .I_SET_VALUE(sv),
      .I_ONOFF_GAP_SETTING(gap), .I_PID_HEAT(ph), .I_PID_COOL(pc), .I_MANUAL_SEL(man),
      .I_AUTO_SEL(aut), .I_MANUAL_MV(mmv), .I_INPUT_ERROR(ie), .I_ERR_ACTION(ea),
      .I_ERR_MV(emv), .I_STOP_HEAT(sh), .I_STOP_COOL(sc), .I_VALVE_MODE(vm),
      .I_VALVE_FEEDBACK_INPUT(fb), .I_VALVE_STOP_MV(vs), .I_HEAT_RATE(hr),
      .I_COOL_RATE(cr), .I_HEAT_CLAMP(hc), .I_COOL_CLAMP(cc),
      .I_SUPPLY_FEED_FORWARD(ff), .I_SUPPLY_CONNECTED(con), .I_SUPPLY_LEVEL(slv),
      .O_HEAT_SIDE_OUTPUT(oh), .O_COOL_SIDE_OUTPUT(oc), .O_MANUAL_MODE(om),
      .O_ERROR_SUBST(oe), .O_ONOFF_STATE(oo), .O_PFF_ACTIVE(op));
   // reference clamp: high limit first, skipped when disabled
   function automatic int lim(input int v, input clamp_t c, input bit en);
      if (!en) return v;
      if (v > c.upper) return c.upper;
      if (v < c.lower) return c.lower;
      return v;
   endfunction : lim
   // compare one result, count it, report a miss
   task automatic chk(input int exp, input logic signed [15:0] got);
      cmp_count++;
      if (got !== 16'(exp)) begin
         error_cnt++;
         $display("wrong value at %0t: got %0d want %0d", $time, got, exp);
      end
   endtask : chk
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : settle
   // one-cycle operator pulse, manual or auto
   task automatic sel(input bit m);
      @(posedge clk);
      if (m) man <= 1;
      else aut <= 1;
      @(posedge clk);
      man <= 0;
      aut <= 0;
      settle(2);
   endtask : sel
   task automatic print_verdict;
      if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (3) @(posedge clk);
      rst <= 0;
      run <= 1;
      // random computed values against random limits
      for (i = 0; i < 8; i++) begin
         @(posedge clk);
         ph <= 16'($random(seed) % 1200);
         pc <= 16'($random(seed) % 1200);
         hc <= {16'(400 + ($random(seed) & 511)), 16'(($random(seed) & 255) - 50)};
         cc <= {16'(400 + ($random(seed) & 511)), 16'(($random(seed) & 255) - 50)};
         settle(3);
         exq.push_back(lim(ph, hc, 1));
         exq.push_back(lim(pc, cc, 1));
         chk(exq.pop_front(), oh);
         chk(exq.pop_front(), oc);
      end
      // stop values per side
      @(posedge clk);
      hc <= dflt;
      cc <= dflt;
      run <= 0;
      sh <= 16'shFFCE;
      sc <= 16'sh0190;
      ie <= 2'b10;
      ea <= 2'b11;
      emv <= 16'sh0320;
      ph <= 16'sh012C;
      settle(3);
      chk(-50, oh);
      chk(400, oc);
      // error already present when run starts
      @(posedge clk);
      run <= 1;
      settle(3);
      chk(0, {15'h0000, oe});
      chk(300, oh);
      @(posedge clk);
      ie <= 2'b00;
      settle(2);
      @(posedge clk);
      ie <= 2'b01;
      settle(3);
      chk(1, {15'h0000, oe});
      chk(1, {15'h0000, om});
      chk(800, oh);
      @(posedge clk);
      hc.upper <= 16'sh02BC;
      settle(3);
      chk(700, oh);
      @(posedge clk);
      hc <= dflt;
      ie <= 2'b00;
      sel(0);
      chk(0, {15'h0000, om});
      // code 0 keeps normal control
      @(posedge clk);
      ea <= 2'b00;
      ie <= 2'b10;
      settle(3);
      chk(0, {15'h0000, oe});
      @(posedge clk);
      ie <= 2'b00;
      ea <= 2'b11;
      mmv <= 16'sh0258;
      sel(1);
      @(posedge clk);
      ie <= 2'b10;
      settle(3);
      chk(0, {15'h0000, oe});
      chk(1, {15'h0000, om});
      chk(600, oh);
      @(posedge clk);
      ie <= 2'b00;
      sel(0);
      // rate limit: 100 %/s rises one count per tick, fall unlimited
      @(posedge clk);
      ph <= 16'sh0000;
      pc <= 16'sh01F4;
      hr <= {16'h03E8, 16'h0000};
      settle(3);
      // heat rises limited, cool falls limited, one count per tick each
      @(posedge clk);
      ph <= 16'sh01F4;
      pc <= 16'sh0000;
      cr <= {16'h0000, 16'h03E8};
      settle(50);
      cmp_count++;
      if ($isunknown({oh, oc}) || oh < 16'sh0002 || oh > 16'sh0007
         || oc < 16'sh01ED || oc > 16'sh01F2) begin
         error_cnt++;
         $display("wrong value at %0t: rate step %0d %0d", $time, oh, oc);
      end
      for (e = 0; e < 8000 && (oh !== 16'sh01F4 || oc !== 16'sh0000); e++) settle(1);
      if (e == 8000) begin
         error_cnt++;
         print_verdict();
      end
      @(posedge clk);
      ph <= 16'sh0000;
      pc <= 16'sh01F4;
      settle(3);
      chk(0, oh);
      chk(500, oc);
      @(posedge clk);
      vm <= 1;
      ph <= 16'sh01F4;
      settle(3);
      chk(500, oh);
      // feed-forward cases: selector, fitted, level
      @(posedge clk);
      vm <= 0;
      hr <= '0;
      cr <= '0;
      for (i = 0; i < 5; i++) begin
         @(posedge clk);
         ff <= (i != 3);
         fit <= (i != 2);
         lvl <= (i == 1) ? 16'h0258 : (i == 4) ? 16'h02BC : 16'h0320;
         settle(4);
         st = (ff && fit && lvl >= 700);
         chk(st ? 500 + ((500 * (1000 - lvl) * 1049) >>> 20) : 500, oh);
         chk(st, {15'h0000, op});
      end
      // valve control without good feedback
      @(posedge clk);
      ff <= 0;
      vm <= 1;
      fb <= 2'b00;
      ph <= 16'sh044C;
      hc.upper <= 16'sh03E8;
      settle(3);
      chk(1100, oh);
      @(posedge clk);
      fb <= 2'b10;
      settle(3);
      chk(1000, oh);
      @(posedge clk);
      fb <= 2'b00;
      run <= 0;
      vs <= 16'sh00C8;
      sh <= 16'sh0064;
      settle(3);
      chk(200, oh);
      @(posedge clk);
      fb <= 2'b10;
      settle(3);
      chk(100, oh);
      @(posedge clk);
      fb <= 2'b00;
      run <= 1;
      settle(3);
      @(posedge clk);
      ie <= 2'b10;
      settle(4);
      chk(200, oh);
      @(posedge clk);
      ie <= 2'b00;
      vm <= 0;
      fb <= 2'b10;
      hc <= dflt;
      sel(0);
      // on/off with gaps: reverse on below 95, off above 110; direct mirrors
      @(posedge clk);
      pb <= 16'h0000;
      st = 0;
      for (e = 0; e < 2; e++) begin
         foreach (pvq[k]) begin
            @(posedge clk);
            da <= e[0];
            pv <= 16'(pvq[k]);
            settle(3);
            if (pvq[k] < 95) st = (e == 0);
            if (pvq[k] > 110) st = (e == 1);
            chk(st * 1000, oh);
            chk(st, {15'h0000, oo});
            chk(0, oc);
         end
      end
      @(posedge clk);
      da <= 0;
      pb <= 16'h0064;
      settle(3);
      chk(1050, oh);
      print_verdict();
   end
endmodule : tb
